// ==== shared/bofbu_map.vh ====
// Constants for the bit operation and flag branch unit.
`ifndef BOFBU_MAP_VH
`define BOFBU_MAP_VH

// Status register flag positions.
`define BOFBU_FLG_C 3'h0
`define BOFBU_FLG_Z 3'h1
`define BOFBU_FLG_N 3'h2
`define BOFBU_FLG_V 3'h3
`define BOFBU_FLG_S 3'h4
`define BOFBU_FLG_H 3'h5
`define BOFBU_FLG_T 3'h6
`define BOFBU_FLG_I 3'h7
`define BOFBU_STATUS_RST 8'h00

// Operation codes on the decoder port.
`define BOFBU_OP_WIDTH 6
`define BOFBU_COMPARE_SKIP_OP 6'h00
`define BOFBU_COMPARE_OP 6'h01
`define BOFBU_COMPARE_WITH_CARRY_OP 6'h02
`define BOFBU_COMPARE_IMMEDIATE_OP 6'h03
`define BOFBU_SKIP_REG_BIT_CLEAR_OP 6'h04
`define BOFBU_SKIP_REG_BIT_SET_OP 6'h05
`define BOFBU_SKIP_IO_BIT_CLEAR_OP 6'h06
`define BOFBU_SKIP_IO_BIT_SET_OP 6'h07
`define BOFBU_BRANCH_FLAG_SET_OP 6'h08
`define BOFBU_BRANCH_FLAG_CLEAR_OP 6'h09
`define BOFBU_BRANCH_EQUAL_OP 6'h0A
`define BOFBU_BRANCH_NOT_EQUAL_OP 6'h0B
`define BOFBU_BRANCH_CARRY_SET_OP 6'h0C
`define BOFBU_BRANCH_CARRY_CLEAR_OP 6'h0D
`define BOFBU_BRANCH_HALF_SET_OP 6'h0E
`define BOFBU_BRANCH_HALF_CLEAR_OP 6'h0F
`define BOFBU_BRANCH_OVERFLOW_CLEAR_OP 6'h10
`define BOFBU_BRANCH_IRQ_ENABLED_OP 6'h11
`define BOFBU_BRANCH_IRQ_DISABLED_OP 6'h12
`define BOFBU_SET_IO_BIT_OP 6'h13
`define BOFBU_CLEAR_IO_BIT_OP 6'h14
`define BOFBU_SHIFT_LEFT_LOGICAL_OP 6'h15
`define BOFBU_SHIFT_RIGHT_LOGICAL_OP 6'h16
`define BOFBU_ROTATE_LEFT_CARRY_OP 6'h17
`define BOFBU_ROTATE_RIGHT_CARRY_OP 6'h18
`define BOFBU_SHIFT_RIGHT_ARITH_OP 6'h19
`define BOFBU_BIT_TO_TRANSFER_OP 6'h1A
`define BOFBU_TRANSFER_TO_BIT_OP 6'h1B
`define BOFBU_CARRY_SET_OP 6'h1C
`define BOFBU_CARRY_CLEAR_OP 6'h1D
`define BOFBU_NEGATIVE_SET_OP 6'h1E
`define BOFBU_NEGATIVE_CLEAR_OP 6'h1F
`define BOFBU_ZERO_SET_OP 6'h20

// Cycle counts of an instruction.
`define BOFBU_CYC_PLAIN 2'h1
`define BOFBU_CYC_TAKEN 2'h2
`define BOFBU_CYC_SKIP_LONG 2'h3
`define BOFBU_CYC_IO_BIT 2'h2

// Program counter steps.
`define BOFBU_PC_STEP 16'h0001
`define BOFBU_PC_SKIP_SHORT 16'h0002
`define BOFBU_PC_SKIP_LONG 16'h0003

// APB register byte offsets.
`define BOFBU_ADDR_WIDTH 8
`define BOFBU_REG_STATUS 8'h00
`define BOFBU_REG_EXEC_INFO 8'h04
`define BOFBU_REG_OP_COUNT 8'h08
`define BOFBU_INFO_TAKEN_BIT 8
`define BOFBU_INFO_OP_LSB 16

`endif

// ==== hw/bofbu_sub.v ====
// Eight-bit subtract with borrow and compare flags.
`timescale 1ns/10ps
module bofbu_sub
(
  input wire [7:0] i_a,
  input wire [7:0] i_b,
  input wire i_borrow,
  output wire [7:0] o_res,
  output wire o_c,
  output wire o_z,
  output wire o_n,
  output wire o_v,
  output wire o_h
);

  wire [8:0] diff;

  // Nine bits keep the borrow out of bit 7 as the carry flag.
  assign diff = {1'b0, i_a} - {1'b0, i_b} - {8'h00, i_borrow};
  assign o_res = diff[7:0];
  assign o_c = diff[8];
  assign o_z = (diff[7:0] == 8'h00);
  assign o_n = diff[7];

  // Signed overflow when operands differ in sign and the result flips.
  assign o_v = (i_a[7] & ~i_b[7] & ~diff[7]) | (~i_a[7] & i_b[7] & diff[7]);

  // Borrow out of bit 3.
  assign o_h = (~i_a[3] & i_b[3]) | (i_b[3] & diff[3]) | (diff[3] & ~i_a[3]);

endmodule // bofbu_sub

// ==== hw/bofbu_core.v ====
// Bit operation and flag branch execution unit with an APB register slave.
// Operation
// - Compare-skip skips next instruction on equal; PC plus 2 or 3, 1-3 cycles.
// - Compares subtract without storing, update Z N V C H in one cycle.
// - Register-bit skips skip on bit clear or set; flags unchanged.
// - I/O-bit skips skip on bit clear or set; PC plus 2 or 3.
// - Generic flag branches test status bit s, set or clear, 1 or 2 cycles.
// - Equal, not-equal, carry-set, carry-clear branches test Z or C.
// - Half-carry branches test H set or clear; flags unchanged.
// - Overflow-clear branch jumps when V is 0; 1 or 2 cycles.
// - Interrupt-enabled branch jumps when I is 1; flags unchanged.
// - Interrupt-disabled branch jumps when I is 0; flags unchanged.
// - Set-I/O-bit writes 1 into bit b only, two cycles.
// - Clear-I/O-bit writes 0 into bit b only, flags unchanged.
// - Logical shifts fill 0, update Z C N V in one cycle.
// - Rotate left takes old carry into bit 0, bit 7 to carry.
// - Rotate right takes old carry into bit 7, bit 0 to carry.
// - Arithmetic right shift keeps bit 7, updates Z C N V.
// - Bit-store copies register bit b into the transfer flag only.
// - Bit-load copies the transfer flag into register bit b.
// - Single-cycle ops set or clear C, set or clear N, set Z.
//
// The APB register port and the register offsets are this design's own decisions.
`timescale 1ns/10ps
`include "bofbu_map.vh"
module bofbu_core
(
  input wire i_clk,
  input wire i_rst_n,
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [7:0] i_paddr,
  input wire [31:0] i_pwdata,
  output wire [31:0] o_prdata,
  output wire o_pready,
  output wire o_pslverr,
  input wire i_op_valid,
  input wire [5:0] i_op_code,
  input wire [7:0] i_rd_val,
  input wire [7:0] i_rr_val,
  input wire [7:0] i_imm,
  input wire [7:0] i_io_val,
  input wire [2:0] i_bit_sel,
  input wire [2:0] i_flag_sel,
  input wire [6:0] i_offset,
  input wire [15:0] i_pc,
  input wire i_next_long,
  output wire o_op_ready,
  output wire o_done,
  output wire [15:0] o_pc_next,
  output wire o_pc_redirect,
  output wire o_rd_we,
  output wire [7:0] o_rd_wdata,
  output wire o_io_we,
  output wire [7:0] o_io_wdata,
  output wire [7:0] o_status
);

  localparam ST_IDLE = 2'b01;
  localparam ST_HOLD = 2'b10;

  reg [1:0] state_ff;
  reg [1:0] cnt_ff;
  reg [7:0] status_ff;
  reg [7:0] nxt_status;
  reg [15:0] pc_ff;
  reg [15:0] nxt_pc;
  reg [7:0] rd_wdata_ff;
  reg [7:0] nxt_rd_wdata;
  reg [7:0] io_wdata_ff;
  reg [7:0] nxt_io_wdata;
  reg nxt_rd_we;
  reg nxt_io_we;
  reg nxt_take;
  reg nxt_redirect;
  reg [1:0] nxt_cycles;
  reg pend_rd_we_ff;
  reg pend_io_we_ff;
  reg pend_redirect_ff;
  reg done_ff;
  reg rd_we_ff;
  reg io_we_ff;
  reg redirect_ff;
  reg [31:0] prdata_ff;
  reg [31:0] op_count_ff;
  reg [5:0] last_op_ff;
  reg last_take_ff;
  reg [7:0] last_res_ff;
  reg is_skip;
  reg is_branch;
  reg is_io_bit;
  reg [7:0] shift_res;
  reg shift_c;
  reg is_shift;
  wire [7:0] sub_b;
  wire sub_borrow;
  wire [7:0] sub_res;
  wire sub_c;
  wire sub_z;
  wire sub_n;
  wire sub_v;
  wire sub_h;
  wire accept;
  wire apb_setup;
  wire apb_write;
  wire addr_ok;
  wire [15:0] branch_target;

  // One-hot mask for a selected bit position.
  function [7:0] bit_mask;
    input [2:0] sel;
    begin
      bit_mask = 8'h01 << sel;
    end
  endfunction

  // Shift and rotate flag update; V is N xor C after the shift.
  function [7:0] shift_flags;
    input [7:0] old;
    input [7:0] res;
    input c;
    begin
      shift_flags = old;
      shift_flags[`BOFBU_FLG_C] = c;
      shift_flags[`BOFBU_FLG_Z] = (res == 8'h00);
      shift_flags[`BOFBU_FLG_N] = res[7];
      shift_flags[`BOFBU_FLG_V] = res[7] ^ c;
    end
  endfunction

  // Compare operand and borrow selection.
  assign sub_b = (i_op_code == `BOFBU_COMPARE_IMMEDIATE_OP) ? i_imm : i_rr_val;
  assign sub_borrow = (i_op_code == `BOFBU_COMPARE_WITH_CARRY_OP) &
    status_ff[`BOFBU_FLG_C];

  bofbu_sub u_sub
  (
    .i_a(i_rd_val),
    .i_b(sub_b),
    .i_borrow(sub_borrow),
    .o_res(sub_res),
    .o_c(sub_c),
    .o_z(sub_z),
    .o_n(sub_n),
    .o_v(sub_v),
    .o_h(sub_h)
  );

  // The offset is a signed word count relative to the next instruction.
  assign branch_target = i_pc + {{9{i_offset[6]}}, i_offset} +
    `BOFBU_PC_STEP;
  assign accept = i_op_valid & state_ff[0];

  // Shift and rotate results.
  always @*
  begin
    is_shift = 1'b1;
    shift_res = i_rd_val;
    shift_c = status_ff[`BOFBU_FLG_C];
    case (i_op_code)
      `BOFBU_SHIFT_LEFT_LOGICAL_OP:
      begin
        shift_res = {i_rd_val[6:0], 1'b0};
        shift_c = i_rd_val[7];
      end
      `BOFBU_SHIFT_RIGHT_LOGICAL_OP:
      begin
        shift_res = {1'b0, i_rd_val[7:1]};
        shift_c = i_rd_val[0];
      end
      `BOFBU_ROTATE_LEFT_CARRY_OP:
      begin
        shift_res = {i_rd_val[6:0], status_ff[`BOFBU_FLG_C]};
        shift_c = i_rd_val[7];
      end
      `BOFBU_ROTATE_RIGHT_CARRY_OP:
      begin
        shift_res = {status_ff[`BOFBU_FLG_C], i_rd_val[7:1]};
        shift_c = i_rd_val[0];
      end
      `BOFBU_SHIFT_RIGHT_ARITH_OP:
      begin
        shift_res = {i_rd_val[7], i_rd_val[7:1]};
        shift_c = i_rd_val[0];
      end
      default:
      begin
        is_shift = 1'b0;
      end
    endcase
  end

  // Decode of condition, flag effect and write-back for one operation.
  always @*
  begin
    nxt_status = status_ff;
    nxt_rd_wdata = i_rd_val;
    nxt_io_wdata = i_io_val;
    nxt_rd_we = 1'b0;
    nxt_io_we = 1'b0;
    nxt_take = 1'b0;
    is_skip = 1'b0;
    is_branch = 1'b0;
    is_io_bit = 1'b0;
    case (i_op_code)
      `BOFBU_COMPARE_SKIP_OP:
      begin
        is_skip = 1'b1;
        nxt_take = (i_rd_val == i_rr_val);
      end
      `BOFBU_COMPARE_OP, `BOFBU_COMPARE_WITH_CARRY_OP,
      `BOFBU_COMPARE_IMMEDIATE_OP:
      begin
        nxt_status[`BOFBU_FLG_C] = sub_c;
        nxt_status[`BOFBU_FLG_N] = sub_n;
        nxt_status[`BOFBU_FLG_V] = sub_v;
        nxt_status[`BOFBU_FLG_H] = sub_h;
        // A multi-byte compare chain keeps zero only while all bytes match.
        if (i_op_code == `BOFBU_COMPARE_WITH_CARRY_OP)
          nxt_status[`BOFBU_FLG_Z] = sub_z & status_ff[`BOFBU_FLG_Z];
        else
          nxt_status[`BOFBU_FLG_Z] = sub_z;
      end
      `BOFBU_SKIP_REG_BIT_CLEAR_OP:
      begin
        is_skip = 1'b1;
        nxt_take = ~i_rr_val[i_bit_sel];
      end
      `BOFBU_SKIP_REG_BIT_SET_OP:
      begin
        is_skip = 1'b1;
        nxt_take = i_rr_val[i_bit_sel];
      end
      `BOFBU_SKIP_IO_BIT_CLEAR_OP:
      begin
        is_skip = 1'b1;
        nxt_take = ~i_io_val[i_bit_sel];
      end
      `BOFBU_SKIP_IO_BIT_SET_OP:
      begin
        is_skip = 1'b1;
        nxt_take = i_io_val[i_bit_sel];
      end
      `BOFBU_BRANCH_FLAG_SET_OP:
      begin
        is_branch = 1'b1;
        nxt_take = status_ff[i_flag_sel];
      end
      `BOFBU_BRANCH_FLAG_CLEAR_OP:
      begin
        is_branch = 1'b1;
        nxt_take = ~status_ff[i_flag_sel];
      end
      `BOFBU_BRANCH_EQUAL_OP:
      begin
        is_branch = 1'b1;
        nxt_take = status_ff[`BOFBU_FLG_Z];
      end
      `BOFBU_BRANCH_NOT_EQUAL_OP:
      begin
        is_branch = 1'b1;
        nxt_take = ~status_ff[`BOFBU_FLG_Z];
      end
      `BOFBU_BRANCH_CARRY_SET_OP:
      begin
        is_branch = 1'b1;
        nxt_take = status_ff[`BOFBU_FLG_C];
      end
      `BOFBU_BRANCH_CARRY_CLEAR_OP:
      begin
        is_branch = 1'b1;
        nxt_take = ~status_ff[`BOFBU_FLG_C];
      end
      `BOFBU_BRANCH_HALF_SET_OP:
      begin
        is_branch = 1'b1;
        nxt_take = status_ff[`BOFBU_FLG_H];
      end
      `BOFBU_BRANCH_HALF_CLEAR_OP:
      begin
        is_branch = 1'b1;
        nxt_take = ~status_ff[`BOFBU_FLG_H];
      end
      `BOFBU_BRANCH_OVERFLOW_CLEAR_OP:
      begin
        is_branch = 1'b1;
        nxt_take = ~status_ff[`BOFBU_FLG_V];
      end
      `BOFBU_BRANCH_IRQ_ENABLED_OP:
      begin
        is_branch = 1'b1;
        nxt_take = status_ff[`BOFBU_FLG_I];
      end
      `BOFBU_BRANCH_IRQ_DISABLED_OP:
      begin
        is_branch = 1'b1;
        nxt_take = ~status_ff[`BOFBU_FLG_I];
      end
      `BOFBU_SET_IO_BIT_OP:
      begin
        is_io_bit = 1'b1;
        nxt_io_we = 1'b1;
        nxt_io_wdata = i_io_val | bit_mask(i_bit_sel);
      end
      `BOFBU_CLEAR_IO_BIT_OP:
      begin
        is_io_bit = 1'b1;
        nxt_io_we = 1'b1;
        nxt_io_wdata = i_io_val & ~bit_mask(i_bit_sel);
      end
      `BOFBU_BIT_TO_TRANSFER_OP:
      begin
        nxt_status[`BOFBU_FLG_T] = i_rr_val[i_bit_sel];
      end
      `BOFBU_TRANSFER_TO_BIT_OP:
      begin
        nxt_rd_we = 1'b1;
        if (status_ff[`BOFBU_FLG_T])
          nxt_rd_wdata = i_rd_val | bit_mask(i_bit_sel);
        else
          nxt_rd_wdata = i_rd_val & ~bit_mask(i_bit_sel);
      end
      `BOFBU_CARRY_SET_OP: nxt_status[`BOFBU_FLG_C] = 1'b1;
      `BOFBU_CARRY_CLEAR_OP: nxt_status[`BOFBU_FLG_C] = 1'b0;
      `BOFBU_NEGATIVE_SET_OP: nxt_status[`BOFBU_FLG_N] = 1'b1;
      `BOFBU_NEGATIVE_CLEAR_OP: nxt_status[`BOFBU_FLG_N] = 1'b0;
      `BOFBU_ZERO_SET_OP: nxt_status[`BOFBU_FLG_Z] = 1'b1;
      default:
      begin
        if (is_shift)
        begin
          nxt_rd_we = 1'b1;
          nxt_rd_wdata = shift_res;
          nxt_status = shift_flags(status_ff, shift_res, shift_c);
        end
      end
    endcase
  end

  // Next program counter and cycle count of the accepted operation.
  always @*
  begin
    nxt_redirect = 1'b0;
    nxt_pc = i_pc + `BOFBU_PC_STEP;
    nxt_cycles = `BOFBU_CYC_PLAIN;
    if (is_skip & nxt_take)
    begin
      nxt_redirect = 1'b1;
      if (i_next_long)
      begin
        nxt_pc = i_pc + `BOFBU_PC_SKIP_LONG;
        nxt_cycles = `BOFBU_CYC_SKIP_LONG;
      end
      else
      begin
        nxt_pc = i_pc + `BOFBU_PC_SKIP_SHORT;
        nxt_cycles = `BOFBU_CYC_TAKEN;
      end
    end
    else if (is_branch & nxt_take)
    begin
      nxt_redirect = 1'b1;
      nxt_pc = branch_target;
      nxt_cycles = `BOFBU_CYC_TAKEN;
    end
    else if (is_io_bit)
    begin
      nxt_cycles = `BOFBU_CYC_IO_BIT;
    end
  end

  // Execution sequencer: results latch on accept, strobes fire on the
  // last cycle so the decoder sees one pulse per instruction.
  always @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      state_ff <= ST_IDLE;
      cnt_ff <= 2'h0;
      pc_ff <= 16'h0000;
      rd_wdata_ff <= 8'h00;
      io_wdata_ff <= 8'h00;
      pend_rd_we_ff <= 1'b0;
      pend_io_we_ff <= 1'b0;
      pend_redirect_ff <= 1'b0;
      done_ff <= 1'b0;
      rd_we_ff <= 1'b0;
      io_we_ff <= 1'b0;
      redirect_ff <= 1'b0;
    end
    else
    begin
      done_ff <= 1'b0;
      rd_we_ff <= 1'b0;
      io_we_ff <= 1'b0;
      redirect_ff <= 1'b0;
      case (state_ff)
        ST_IDLE:
        begin
          if (accept)
          begin
            pc_ff <= nxt_pc;
            rd_wdata_ff <= nxt_rd_wdata;
            io_wdata_ff <= nxt_io_wdata;
            pend_rd_we_ff <= nxt_rd_we;
            pend_io_we_ff <= nxt_io_we;
            pend_redirect_ff <= nxt_redirect;
            if (nxt_cycles == `BOFBU_CYC_PLAIN)
            begin
              done_ff <= 1'b1;
              rd_we_ff <= nxt_rd_we;
              io_we_ff <= nxt_io_we;
              redirect_ff <= nxt_redirect;
            end
            else
            begin
              cnt_ff <= nxt_cycles - 2'h2;
              state_ff <= ST_HOLD;
            end
          end
        end
        ST_HOLD:
        begin
          if (cnt_ff == 2'h0)
          begin
            done_ff <= 1'b1;
            rd_we_ff <= pend_rd_we_ff;
            io_we_ff <= pend_io_we_ff;
            redirect_ff <= pend_redirect_ff;
            state_ff <= ST_IDLE;
          end
          else
          begin
            cnt_ff <= cnt_ff - 2'h1;
          end
        end
        default:
        begin
          state_ff <= ST_IDLE;
        end
      endcase
    end
  end

  // APB decode; the slave never inserts wait states.
  assign apb_setup = i_psel & ~i_penable;
  assign apb_write = i_psel & i_penable & i_pwrite;
  assign addr_ok = (i_paddr == `BOFBU_REG_STATUS) |
    (i_paddr == `BOFBU_REG_EXEC_INFO) | (i_paddr == `BOFBU_REG_OP_COUNT);

  // Status register: an instruction's flag update wins over a software
  // write in the same cycle, so a flag event is never lost.
  always @(posedge i_clk)
  begin
    if (!i_rst_n)
      status_ff <= `BOFBU_STATUS_RST;
    else if (accept)
      status_ff <= nxt_status;
    else if (apb_write & (i_paddr == `BOFBU_REG_STATUS))
      status_ff <= i_pwdata[7:0];
  end

  // Execution record visible to software.
  always @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      op_count_ff <= 32'h00000000;
      last_op_ff <= 6'h00;
      last_take_ff <= 1'b0;
      last_res_ff <= 8'h00;
    end
    else if (accept)
    begin
      op_count_ff <= op_count_ff + 32'h00000001;
      last_op_ff <= i_op_code;
      last_take_ff <= nxt_take;
      last_res_ff <= nxt_io_we ? nxt_io_wdata :
        (nxt_rd_we ? nxt_rd_wdata : sub_res);
    end
  end

  // Read data is captured in the setup phase, ready for the access phase.
  always @(posedge i_clk)
  begin
    if (!i_rst_n)
      prdata_ff <= 32'h00000000;
    else if (apb_setup)
    begin
      case (i_paddr)
        `BOFBU_REG_STATUS: prdata_ff <= {24'h000000, status_ff};
        `BOFBU_REG_EXEC_INFO: prdata_ff <= {10'h000, last_op_ff,
          7'h00, last_take_ff, last_res_ff};
        `BOFBU_REG_OP_COUNT: prdata_ff <= op_count_ff;
        default: prdata_ff <= 32'h00000000;
      endcase
    end
  end

  assign o_prdata = prdata_ff;
  assign o_pready = 1'b1;
  assign o_pslverr = i_psel & i_penable & ~addr_ok;
  assign o_op_ready = state_ff[0];
  assign o_done = done_ff;
  assign o_pc_next = pc_ff;
  assign o_pc_redirect = redirect_ff;
  assign o_rd_we = rd_we_ff;
  assign o_rd_wdata = rd_wdata_ff;
  assign o_io_we = io_we_ff;
  assign o_io_wdata = io_wdata_ff;
  assign o_status = status_ff;

endmodule // bofbu_core

// ==== test/bofbu_properties.sv ====
// Port checks for the bit operation and flag branch unit.
`timescale 1ns/10ps
`include "bofbu_map.vh"
module bofbu_properties
(
  input wire i_clk,
  input wire i_rst_n,
  input wire i_op_valid,
  input wire [5:0] i_op_code,
  input wire [7:0] i_rd_val,
  input wire [7:0] i_rr_val,
  input wire [7:0] i_io_val,
  input wire [2:0] i_bit_sel,
  input wire [6:0] i_offset,
  input wire [15:0] i_pc,
  input wire i_next_long,
  input wire o_op_ready,
  input wire o_done,
  input wire [15:0] o_pc_next,
  input wire o_pc_redirect,
  input wire o_rd_we,
  input wire [7:0] o_rd_wdata,
  input wire o_io_we,
  input wire [7:0] o_io_wdata,
  input wire [7:0] o_status
);
  // An op is taken only when offered while the unit is idle.
  wire acc = i_op_valid && o_op_ready;
  wire [15:0] tgt = i_pc + {{9{i_offset[6]}}, i_offset} + 16'h0001;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  a_shift_left: assert property (
    acc && i_op_code == `BOFBU_SHIFT_LEFT_LOGICAL_OP |=> o_done && o_rd_we
    && o_rd_wdata == {$past(i_rd_val[6:0]), 1'b0})
    else $error("shift left result wrong");
  a_io_set_bit: assert property (
    acc && i_op_code == `BOFBU_SET_IO_BIT_OP |=> !o_done ##1 o_done
    && o_io_we && o_io_wdata ==
    ($past(i_io_val, 2) | (8'h01 << $past(i_bit_sel, 2))))
    else $error("set io bit wrong");
  a_branch_taken: assert property (
    acc && i_op_code == `BOFBU_BRANCH_EQUAL_OP && o_status[1] |=> !o_done
    ##1 o_done && o_pc_redirect && o_pc_next == $past(tgt, 2))
    else $error("taken branch wrong");
  a_branch_fall: assert property (
    acc && i_op_code == `BOFBU_BRANCH_NOT_EQUAL_OP && o_status[1] |=>
    o_done && !o_pc_redirect && o_pc_next == $past(i_pc) + 16'h0001)
    else $error("fall through wrong");
  a_carry_set: assert property (
    acc && i_op_code == `BOFBU_CARRY_SET_OP |=>
    o_done && o_status == ($past(o_status) | 8'h01))
    else $error("carry set wrong");
  a_bit_load: assert property (
    acc && i_op_code == `BOFBU_TRANSFER_TO_BIT_OP |=> o_rd_we
    && o_rd_wdata[$past(i_bit_sel)] == $past(o_status[6]) && $stable(o_status))
    else $error("bit load wrong");
  a_skip_long: assert property (
    acc && i_op_code == `BOFBU_COMPARE_SKIP_OP && i_rd_val == i_rr_val
    && i_next_long |=> !o_done [*2] ##1 o_done && o_pc_redirect
    && o_pc_next == $past(i_pc, 3) + 16'h0003)
    else $error("long skip wrong");
  a_redirect_done: assert property (
    o_pc_redirect |-> o_done)
    else $error("redirect without done");
endmodule // bofbu_properties

bind bofbu_core bofbu_properties u_chk (.i_clk, .i_rst_n, .i_op_valid,
  .i_op_code, .i_rd_val, .i_rr_val, .i_io_val, .i_bit_sel, .i_offset,
  .i_pc, .i_next_long, .o_op_ready, .o_done, .o_pc_next, .o_pc_redirect,
  .o_rd_we, .o_rd_wdata, .o_io_we, .o_io_wdata, .o_status);

// ==== test/bofbu_partner.sv ====
// Register file and I/O space model beside the execution unit.
`timescale 1ns/10ps
module bofbu_partner
(
  input wire i_clk,
  input wire i_load,
  input wire [7:0] i_load_rd,
  input wire [7:0] i_load_io,
  input wire i_rd_we,
  input wire [7:0] i_rd_wdata,
  input wire i_io_we,
  input wire [7:0] i_io_wdata,
  output wire [7:0] o_rd_val,
  output wire [7:0] o_io_val
);
  reg [7:0] rd_ff = 8'h00;
  reg [7:0] io_ff = 8'h00;
  // Write-backs land on the done edge, so a following op sees them.
  always @(posedge i_clk)
  begin
    if (i_load)
    begin
      rd_ff <= i_load_rd;
      io_ff <= i_load_io;
    end
    if (i_rd_we)
      rd_ff <= i_rd_wdata;
    if (i_io_we)
      io_ff <= i_io_wdata;
  end
  assign o_rd_val = rd_ff;
  assign o_io_val = io_ff;
endmodule // bofbu_partner

// ==== test/testbench.sv ====
// Directed tests for the bit operation and flag branch unit.
`timescale 1ns/10ps
`include "bofbu_map.vh"
module testbench;
  logic i_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0;
  logic i_op_valid = 1'b0, i_next_long = 1'b0, i_load = 1'b0;
  logic [7:0] i_paddr = 8'h00, i_imm = 8'h00, i_rr_val = 8'h00;
  logic [7:0] i_load_rd = 8'h00, i_load_io = 8'h00;
  logic [31:0] i_pwdata = 32'h0, rdat;
  logic [5:0] i_op_code = 6'h00;
  logic [2:0] i_bit_sel = 3'h0, i_flag_sel = 3'h0;
  logic [6:0] i_offset = 7'h00;
  logic [15:0] i_pc = 16'h0000;
  wire [31:0] o_prdata;
  wire o_pready, o_pslverr, o_op_ready, o_done, o_pc_redirect, o_rd_we;
  wire o_io_we;
  wire [15:0] o_pc_next;
  wire [7:0] o_rd_wdata, o_io_wdata, o_status, i_rd_val, i_io_val;
  int miscompares = 0;
  int tests_run = 0;
  int cyc;
  logic rerr, redir, tk, sk;
  int fb [0:10] = '{6, 6, 1, 1, 0, 0, 5, 5, 3, 7, 7};
  logic [10:0] inv = 11'h5AA;
  bofbu_core i_dut (.i_clk, .i_rst_n, .i_psel, .i_penable, .i_pwrite,
    .i_paddr, .i_pwdata, .o_prdata, .o_pready, .o_pslverr, .i_op_valid,
    .i_op_code, .i_rd_val, .i_rr_val, .i_imm, .i_io_val, .i_bit_sel,
    .i_flag_sel, .i_offset, .i_pc, .i_next_long, .o_op_ready, .o_done,
    .o_pc_next, .o_pc_redirect, .o_rd_we, .o_rd_wdata, .o_io_we,
    .o_io_wdata, .o_status);
  bofbu_partner i_far (.i_clk, .i_load, .i_load_rd, .i_load_io,
    .i_rd_we(o_rd_we), .i_rd_wdata(o_rd_wdata), .i_io_we(o_io_we),
    .i_io_wdata(o_io_wdata), .o_rd_val(i_rd_val), .o_io_val(i_io_val));
  // A 5 ns period gives the 200 MHz core clock.
  always #2.5 i_clk = ~i_clk;
  task automatic chk(input logic [32:0] got, exp, input string what);
    tests_run++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // One APB transfer; the request stands until pready is seen high.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_psel <= 1'b1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_clk);
    i_penable <= 1'b1;
    do
    begin
      @(posedge i_clk);
    end while (o_pready !== 1'b1);
    rdat = o_prdata;
    rerr = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  endtask
  task automatic wst(input logic [7:0] v);
    apb(1'b1, `BOFBU_REG_STATUS, {24'h000000, v});
  endtask
  task automatic ld(input logic [7:0] rd, io);
    @(posedge i_clk);
    i_load <= 1'b1;
    i_load_rd <= rd;
    i_load_io <= io;
    @(posedge i_clk);
    i_load <= 1'b0;
  endtask
  // Offer one op and count edges from acceptance to the done pulse.
  task automatic run(input logic [5:0] c);
    @(posedge i_clk);
    i_op_code <= c;
    i_op_valid <= 1'b1;
    @(posedge i_clk);
    i_op_valid <= 1'b0;
    cyc = 0;
    do
    begin
      @(posedge i_clk);
      cyc++;
    end while (o_done !== 1'b1 && cyc < 8);
    redir = o_pc_redirect;
  endtask
  task automatic results;
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial
  begin
    repeat (6) @(posedge i_clk);
    i_rst_n <= 1'b1;
    wst(8'hA5);
    apb(1'b0, `BOFBU_REG_STATUS, 32'h0);
    chk(rdat, 32'h000000A5, "status readback");
    apb(1'b0, 8'h0C, 32'h0);
    chk({rerr, rdat}, 33'h100000000, "unmapped read");
    $display("register test done");
    // Every flag branch with its flag low and high, backwards by two.
    for (int i = 0; i < 11; i++)
      for (int v = 0; v < 2; v++)
      begin
        wst(8'(v) << fb[i]);
        i_flag_sel <= 3'(fb[i]);
        i_pc <= 16'h0100;
        i_offset <= 7'h7E;
        tk = v[0] ^ inv[i];
        run(`BOFBU_BRANCH_FLAG_SET_OP + 6'(i));
        chk(cyc, tk ? 2 : 1, "branch cycles");
        chk(redir, tk, "branch redirect");
        chk(o_pc_next, tk ? 16'h00FF : 16'h0101, "branch target");
        chk(o_status, 8'(v) << fb[i], "branch flags");
      end
    $display("branch test done");
    // Compare-skip, then register and I/O bit skips; 0xA5 has bit 2 set.
    wst(8'h00);
    ld(8'hA5, 8'hA5);
    for (int j = 0; j < 5; j++)
      for (int b = 1; b < 3; b++)
        for (int nl = 0; nl < 2; nl++)
        begin
          i_rr_val <= (j == 0 && b == 1) ? 8'h5A : 8'hA5;
          i_bit_sel <= 3'(b);
          i_next_long <= nl[0];
          i_pc <= 16'h0200;
          sk = (j == 0) ? (b == 2) : (b == 2) != j[0];
          run(j == 0 ? `BOFBU_COMPARE_SKIP_OP : 6'(j + 3));
          chk(cyc, sk ? 2 + nl : 1, "skip cycles");
          chk(o_pc_next, sk ? 16'h0202 + nl : 16'h0201, "skip pc");
          chk(o_status, 8'h00, "skip flags");
        end
    $display("skip test done");
    // Compare, compare with carry and immediate compare flag results.
    for (int i = 0; i < 3; i++)
    begin
      wst(i == 1 ? 8'h03 : 8'h00);
      ld(i == 0 ? 8'h10 : (i == 1 ? 8'h20 : 8'h80), 8'h00);
      i_rr_val <= i == 0 ? 8'h20 : 8'h1F;
      i_imm <= 8'h01;
      run(`BOFBU_COMPARE_OP + 6'(i));
      chk(cyc, 1, "compare cycles");
      chk(o_status, i == 0 ? 8'h05 : (i == 1 ? 8'h22 : 8'h28), "cmp");
    end
    $display("compare test done");
    // Shifts and rotates of 0x81 with carry set beforehand.
    for (int i = 0; i < 5; i++)
    begin
      wst(8'h01);
      ld(8'h81, 8'h00);
      run(`BOFBU_SHIFT_LEFT_LOGICAL_OP + 6'(i));
      chk(o_rd_wdata, i == 0 ? 8'h02 : (i == 1 ? 8'h40 :
        (i == 2 ? 8'h03 : 8'hC0)), "shift result");
      chk({cyc[1:0], o_status}, i < 3 ? 10'h109 : 10'h105, "shift");
    end
    $display("shift test done");
    // Set bit 3 then clear bit 0 of one I/O register; flags stay put.
    wst(8'h00);
    ld(8'h00, 8'hA5);
    i_bit_sel <= 3'h3;
    run(`BOFBU_SET_IO_BIT_OP);
    chk({cyc[1:0], o_io_wdata}, 10'h2AD, "set io bit");
    i_bit_sel <= 3'h0;
    run(`BOFBU_CLEAR_IO_BIT_OP);
    chk(o_io_wdata, 8'hAC, "clear io bit");
    chk(o_status, 8'h00, "io flags");
    ld(8'h10, 8'h00);
    i_rr_val <= 8'h10;
    i_bit_sel <= 3'h4;
    run(`BOFBU_BIT_TO_TRANSFER_OP);
    chk(o_status, 8'h40, "bit store");
    ld(8'h00, 8'h00);
    i_bit_sel <= 3'h7;
    run(`BOFBU_TRANSFER_TO_BIT_OP);
    chk({o_rd_wdata, o_status}, 16'h8040, "bit load");
    apb(1'b0, `BOFBU_REG_EXEC_INFO, 32'h0);
    chk(rdat, 32'h001B0080, "exec info");
    $display("bit test done");
    wst(8'h00);
    for (int i = 0; i < 5; i++)
    begin
      run(i == 2 ? `BOFBU_ZERO_SET_OP : `BOFBU_CARRY_SET_OP + 6'(i < 2 ?
        2 * i : 2 * i - 5));
      chk(o_status, i == 0 ? 8'h01 : (i == 1 ? 8'h05 : (i == 2 ? 8'h07 :
        (i == 3 ? 8'h06 : 8'h02))), "flag op");
    end
    $display("flag test done");
    apb(1'b0, `BOFBU_REG_OP_COUNT, 32'h0);
    chk(rdat, 32'h0000003B, "op count");
    results;
  end
  // The whole run needs a few hundred cycles; this cuts a hang short.
  initial
  begin
    #50000;
    miscompares++;
    results;
  end
endmodule // testbench
